//--- pkg/amc_consts.svh
// Register addresses, field positions, reset values and timing counts of the converter control
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH

`define AMC_RESULT_ADDR   8'h84
`define AMC_CONTROL_ADDR  8'hA0
`define AMC_ENABLE_BIT    5
`define AMC_DONE_BIT      4
`define AMC_START_BIT     3
`define AMC_SEL_MSB       2
`define AMC_SEL_LSB       0
`define AMC_RESERVED_READ 2'h3
`define AMC_CONTROL_RESET 8'hC0
`define AMC_RESULT_RESET  8'h00
`define AMC_OSC_PER_MC    12
`define AMC_CONV_MC       40
`define AMC_CHANNELS      5

`endif

//--- pkg/amc_pkg.sv
// Types shared by the converter control design
package amc_pkg;
    typedef logic [7:0] amc_byte_t;
    typedef logic [2:0] amc_sel_t;
    typedef enum logic [1:0] {AMC_IDLE, AMC_BUSY, AMC_DONE} amc_state_e;
endpackage

//--- logic/amc_cycle_tick.sv
// Machine-cycle tick generator: one pulse every DIV clocks after a restart
`timescale 1ns/10ps
module amc_cycle_tick #(
    parameter int DIV = 12
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic restart,
    output logic      tick
);
    localparam int W = (DIV < 2) ? 1 : $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;

    generate
        if (DIV < 2) begin : g_bad_div
            $error("amc_cycle_tick needs DIV of at least 2");
        end
    endgenerate

    // Restart realigns the phase so a conversion spans whole machine cycles
    always_ff @(posedge ref_clk) begin
        if (!rstn || restart || cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // Pulse on the last oscillator period of each machine cycle
    assign tick = !restart && (cnt == LAST);
endmodule

//--- logic/amc_converter_ctrl.sv
// Control logic for the five-channel multiplexed 8-bit converter
`timescale 1ns/10ps
`include "amc_consts.svh"

module amc_converter_ctrl #(
    parameter int MC_DIV  = `AMC_OSC_PER_MC,
    parameter int CONV_MC = `AMC_CONV_MC
) (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic [7:0]          sfr_addr,
    input  wire amc_pkg::amc_byte_t  sfr_wdata,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    output amc_pkg::amc_byte_t       sfr_rdata,
    input  wire logic                converter_interrupt_enable,
    input  wire logic                idle_mode,
    input  wire logic                power_down,
    input  wire amc_pkg::amc_byte_t  adc_code,
    output logic [4:0]               analog_sel,
    output logic                     conv_run,
    output logic                     conversion_irq,
    input  wire logic [4:0]          port_latch,
    output logic [4:0]               port_rd_data,
    input  wire logic [4:0]          pin_in,
    output logic [4:0]               pin_out,
    output logic [4:0]               pin_oe
);
    import amc_pkg::*;

    localparam int CONV_CLKS = CONV_MC * MC_DIV;
    localparam int MCW       = (CONV_MC < 2) ? 1 : $clog2(CONV_MC);
    localparam logic [MCW-1:0] MC_LAST = MCW'(CONV_MC - 1);

    generate
        if (CONV_MC < 2 || MC_DIV < 2) begin : g_bad_timing
            $error("amc_converter_ctrl needs CONV_MC and MC_DIV of at least 2");
        end
    endgenerate

    amc_state_e     state;
    amc_state_e     next_state;
    logic           converter_enable;
    amc_sel_t       channel_sel;
    amc_byte_t      conversion_result_reg;
    logic [MCW-1:0] mc_cnt;
    logic [4:0]     pin_meta;
    logic [4:0]     pin_sync;
    logic           mc_tick;

    // Bus decode; only whole-byte accesses exist, no bit addresses decode here
    wire hit_ctrl    = (sfr_addr == `AMC_CONTROL_ADDR);
    wire hit_result  = (sfr_addr == `AMC_RESULT_ADDR);
    wire wr_ctrl     = sfr_wr && hit_ctrl;
    wire rd_result   = sfr_rd && hit_result;
    wire next_enable = sfr_wdata[`AMC_ENABLE_BIT];
    wire start_req   = wr_ctrl && sfr_wdata[`AMC_START_BIT] && next_enable;

    // Status bits are views of the sequencer state, so both can never be one
    wire conversion_start_bit = (state == AMC_BUSY);
    wire conversion_done_flag = (state == AMC_DONE);
    wire sleep_abort          = idle_mode || power_down;
    wire complete             = conversion_start_bit && mc_tick && (mc_cnt == MC_LAST);
    wire start_ok             = (state == AMC_IDLE) && start_req && !sleep_abort;

    // Select decode; codes above four pick no pin
    wire [4:0] sel_onehot = (channel_sel < 3'h5) ? (5'h01 << channel_sel) : 5'h00;

    wire amc_byte_t ctrl_view = {`AMC_RESERVED_READ, converter_enable, conversion_done_flag,
                                 conversion_start_bit, channel_sel};
    wire amc_byte_t next_rdata = !sfr_rd     ? sfr_rdata :
                                 hit_ctrl   ? ctrl_view :
                                 hit_result ? conversion_result_reg : 8'h00;

    // Sequencer: completion beats a same-cycle result read, which only acts in DONE
    always_comb begin
        next_state = state;
        unique case (state)
            AMC_IDLE: begin
                if (start_ok) begin
                    next_state = AMC_BUSY;
                end
            end
            AMC_BUSY: begin
                if (sleep_abort || !converter_enable) begin
                    next_state = AMC_IDLE;
                end else if (complete) begin
                    next_state = AMC_DONE;
                end
            end
            AMC_DONE: begin
                if (rd_result) begin
                    next_state = AMC_IDLE;
                end
            end
        endcase
    end

    // Start-bit writes of zero do not reach the state; only completion, idle/power-down or a cleared enable ends BUSY
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= AMC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Enable follows every control write; reset forces it low
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            converter_enable <= 1'b0;
        end else if (wr_ctrl) begin
            converter_enable <= next_enable;
        end
    end

    // Select is frozen while busy or done so the sampled pin cannot move
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            channel_sel <= 3'h0;
        end else if (wr_ctrl && state == AMC_IDLE) begin
            channel_sel <= sfr_wdata[`AMC_SEL_MSB:`AMC_SEL_LSB];
        end
    end

    // Machine-cycle counter restarts with each accepted start
    always_ff @(posedge ref_clk) begin
        if (!rstn || start_ok) begin
            mc_cnt <= '0;
        end else if (conversion_start_bit && mc_tick) begin
            mc_cnt <= mc_cnt + 1'b1;
        end
    end

    amc_cycle_tick #(
        .DIV(MC_DIV)
    ) u_tick (
        .ref_clk(ref_clk),
        .rstn   (rstn),
        .restart(start_ok),
        .tick   (mc_tick)
    );

    // Result latches only at completion, which cannot happen while DONE holds
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            conversion_result_reg <= `AMC_RESULT_RESET;
        end else if (complete && next_state == AMC_DONE) begin
            conversion_result_reg <= adc_code;
        end
    end

    // Read data registered, answer one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_rdata;
        end
    end

    // Pin synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_meta <= 5'h1F;
            pin_sync <= 5'h1F;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Pin sharing: drivers released while enabled since analog pins would fight them
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_oe       <= 5'h00;
            port_rd_data <= 5'h1F;
            analog_sel   <= 5'h00;
        end else begin
            pin_oe       <= converter_enable ? 5'h00 : ~port_latch;
            port_rd_data <= converter_enable ? (pin_sync | sel_onehot) : pin_sync;
            analog_sel   <= converter_enable ? sel_onehot : 5'h00;
        end
    end

    // Low-drive only: a latch of one leaves the pin to its pull-up
    assign pin_out        = 5'h00;
    assign conv_run       = conversion_start_bit;
    assign conversion_irq = conversion_done_flag && converter_interrupt_enable;

    // Helper: clocks since the accepted start
    int conv_age;
    always_ff @(posedge ref_clk) begin
        if (!rstn || start_ok) begin
            conv_age <= 0;
        end else if (conversion_start_bit) begin
            conv_age <= conv_age + 1;
        end
    end

    localparam int LAST_AGE = CONV_CLKS - 1;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Reset disables every check, so a reset in mid-run cannot trip a stale attempt
    // Status exclusivity and timing of one conversion
    a_start_done_excl: assert property (
        !(conversion_start_bit && conversion_done_flag))
        else $error("start bit and done flag both set");
    a_conv_length: assert property (
        $rose(conversion_done_flag) |-> $past(conv_age) == LAST_AGE)
        else $error("conversion length wrong");
    a_done_from_busy: assert property (
        $rose(conversion_done_flag) |-> $past(conversion_start_bit))
        else $error("done flag set without a conversion");

    // Enable and start bit: enable follows control writes; start set by an accepted start, cleared only by completion or abort
    a_enable_write: assert property (
        wr_ctrl |=> converter_enable == $past(next_enable))
        else $error("enable bit did not follow control write");
    a_start_accept: assert property (
        state == AMC_IDLE && start_req && !sleep_abort |=> conversion_start_bit)
        else $error("accepted start did not set start bit");
    a_busy_holds: assert property (
        conversion_start_bit && !sleep_abort && converter_enable && !complete
        |=> conversion_start_bit)
        else $error("start bit dropped before completion");
    a_start_ignored: assert property (
        conversion_start_bit && start_req && !complete && !sleep_abort
        |=> conv_age == $past(conv_age) + 1)
        else $error("start while busy disturbed conversion");

    // Done flag, result register and interrupt request
    a_read_clears: assert property (
        conversion_done_flag && rd_result |=> !conversion_done_flag)
        else $error("result read did not clear done flag");
    a_done_sticky: assert property (
        conversion_done_flag && !rd_result |=> conversion_done_flag)
        else $error("done flag lost without result read");
    a_result_capture: assert property (
        $rose(conversion_done_flag) |-> conversion_result_reg == $past(adc_code))
        else $error("result not taken from converter at completion");
    a_result_hold: assert property (
        conversion_done_flag ##1 conversion_done_flag |-> $stable(conversion_result_reg))
        else $error("result changed while done flag set");
    a_result_read: assert property (
        sfr_rd && hit_result |=> sfr_rdata == $past(conversion_result_reg))
        else $error("result read returned wrong data");
    a_ctrl_bytes: assert property (
        sfr_rd && hit_ctrl |=> sfr_rdata[7:6] == 2'h3)
        else $error("control read upper bits wrong");
    a_irq_level: assert property (
        conversion_done_flag && converter_interrupt_enable |-> conversion_irq)
        else $error("interrupt missing");
    a_irq_quiet: assert property (
        !conversion_done_flag |-> !conversion_irq)
        else $error("interrupt without done flag");

    // Sleep and enable aborts
    a_sleep_abort: assert property (
        conversion_start_bit && sleep_abort |=> state == AMC_IDLE && !conversion_done_flag)
        else $error("sleep did not abort conversion");
    a_idle_keeps: assert property (
        conversion_done_flag && idle_mode && !rd_result |=> conversion_done_flag)
        else $error("idle lost completed result");
    a_enable_abort: assert property (
        conversion_start_bit && !converter_enable
        |=> !conversion_start_bit && !conversion_done_flag)
        else $error("clearing enable did not abort conversion");

    // Select and pin sharing
    a_sel_frozen: assert property (
        state != AMC_IDLE |=> $stable(channel_sel))
        else $error("select changed while busy or done");
    a_sel_top_pin: assert property (
        converter_enable && channel_sel == 3'h4 |=> analog_sel == 5'h10)
        else $error("code four did not pick the top pin");
    a_sel_none: assert property (
        channel_sel > 3'h4 |=> analog_sel == 5'h00)
        else $error("unused select code picked a pin");
    a_sel_reads_one: assert property (
        converter_enable ##1 converter_enable
        |=> (port_rd_data & $past(sel_onehot)) == $past(sel_onehot))
        else $error("selected pin did not read one");
    a_disabled_pins: assert property (
        !converter_enable |=> pin_oe == ~$past(port_latch) && analog_sel == 5'h00)
        else $error("disabled pins not digital");
    a_enabled_release: assert property (
        converter_enable |=> pin_oe == 5'h00)
        else $error("pin driver left on while converter enabled");

    // Main scenarios
    c_complete: cover property ($rose(conversion_done_flag));
    c_read_clear: cover property (conversion_done_flag && rd_result);
    c_blocked_start: cover property (conversion_start_bit && start_req);
    c_idle_abort: cover property (conversion_start_bit && idle_mode);
    c_enable_abort: cover property (conversion_start_bit && !converter_enable);
endmodule

//--- dv/amc_pin_model.sv
// Behavioural model of the five analog input pins and the codes they convert to
`timescale 1ns/10ps
module amc_pin_model (
    input  wire logic          ref_clk,
    input  wire logic [4:0]    analog_sel,
    input  wire logic [4:0]    pin_out,
    input  wire logic [4:0]    pin_oe,
    input  wire logic [4:0]    ext_level,
    output amc_pkg::amc_byte_t adc_code,
    output logic [4:0]         pin_in
);
    import amc_pkg::*;
    amc_byte_t churn = 8'h00;

    // With no channel picked the code churns, so a stray capture shows up
    always @(posedge ref_clk) churn <= churn + 8'h01;

    // One fixed code per channel: 3C, 4D, 5E, 6F, 80
    always_comb begin
        adc_code = ~churn;
        for (int i = 0; i < 5; i++) begin
            if (analog_sel == 5'(1 << i)) adc_code = 8'(8'h3C + 8'h11 * i);
        end
    end

    // Outside sources never override a driven pad; a released pad shows the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- dv/amc_converter_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "amc_consts.svh"
module amc_converter_ctrl_tb;
    import amc_pkg::*;
    localparam int         N  = 4;  // Two ticks of two clocks keep runs short
    localparam logic [7:0] CA = `AMC_CONTROL_ADDR;
    localparam logic [7:0] RA = `AMC_RESULT_ADDR;
    logic       ref_clk    = 1'b0;
    logic       rstn       = 1'b0;
    logic [7:0] sfr_addr   = 8'h00;
    amc_byte_t  sfr_wdata  = 8'h00;
    logic       sfr_wr     = 1'b0;
    logic       sfr_rd     = 1'b0;
    logic       irq_en     = 1'b0;
    logic       idle_mode  = 1'b0;
    logic       power_down = 1'b0;
    logic [4:0] port_latch = 5'h00;
    logic [4:0] ext_level  = 5'h00;
    amc_byte_t  sfr_rdata, adc_code;
    logic [4:0] analog_sel, port_rd_data, pin_in, pin_out, pin_oe;
    logic       conv_run, conversion_irq;
    int         n_fail     = 0;
    int         num_checks = 0;
    int         cyc        = 0;

    amc_converter_ctrl #(.MC_DIV(2), .CONV_MC(2)) amc_converter_ctrl_i (
        .ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .converter_interrupt_enable(irq_en), .idle_mode(idle_mode),
        .power_down(power_down), .adc_code(adc_code), .analog_sel(analog_sel),
        .conv_run(conv_run), .conversion_irq(conversion_irq), .port_latch(port_latch),
        .port_rd_data(port_rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    amc_pin_model amc_pin_model_i (
        .ref_clk(ref_clk), .analog_sel(analog_sel), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .adc_code(adc_code), .pin_in(pin_in));

    // Clock and a cycle count for timing the conversions
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Register cycles; each returns just after the edge that took the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask
    // Bounded wait for the start bit to drop, then judge the span from t0
    task automatic finish_conv(input int t0);
        int k;
        k = 0;
        while (conv_run === 1'b1 && k < 100) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk(8'(cyc - t0), 8'(N));
    endtask
    task automatic t_reset(input bit pulse);
        logic [7:0] d;
        if (pulse) begin
            @(posedge ref_clk);
            rstn <= 1'b0;
            repeat (2) @(posedge ref_clk);
            rstn <= 1'b1;
        end
        rd(CA, d);
        chk(d, `AMC_CONTROL_RESET);
        rd(RA, d);
        chk(d, `AMC_RESULT_RESET);
    endtask
    task automatic t_convert(input int c);
        logic [7:0] d;
        logic [7:0] s;
        int         t0;
        s = 8'(c);
        wr(CA, 8'h20 | s);
        wr(CA, 8'h28 | s);
        t0 = cyc;
        chk({7'h00, conv_run}, 8'h01);
        chk({3'h0, analog_sel}, 8'(1 << c));
        finish_conv(t0);
        chk({7'h00, conversion_irq}, {7'h00, irq_en});
        rd(CA, d);
        chk(d, 8'hF0 | s);
        chk({3'h0, port_rd_data}, 8'(1 << c));
        wr(CA, 8'h28 | 8'((c + 1) % 5));
        chk({7'h00, conv_run}, 8'h00);
        rd(CA, d);
        chk(d, 8'hF0 | s);
        rd(RA, d);
        chk(d, 8'(8'h3C + 8'h11 * s));
        rd(CA, d);
        chk(d, 8'hE0 | s);
    endtask
    // A second start and a new select written mid-conversion change nothing
    task automatic t_busy();
        logic [7:0] d;
        int         t0;
        wr(CA, 8'h2A);
        t0 = cyc;
        wr(CA, 8'h28);
        finish_conv(t0);
        rd(RA, d);
        chk(d, 8'h5E);
    endtask
    task automatic t_abort(input bit pd);
        logic [7:0] d;
        wr(CA, 8'h29);
        @(posedge ref_clk);
        idle_mode  <= !pd;
        power_down <= pd;
        repeat (2) @(posedge ref_clk);
        idle_mode  <= 1'b0;
        power_down <= 1'b0;
        repeat (N + 2) @(posedge ref_clk);
        rd(CA, d);
        chk(d, 8'hE1);
        rd(RA, d);
        chk(d, 8'h5E);
    endtask
    task automatic t_idle_keep();
        logic [7:0] d;
        wr(CA, 8'h2B);
        wr(CA, 8'h23);
        repeat (N - 1) @(posedge ref_clk);
        idle_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        idle_mode <= 1'b0;
        rd(CA, d);
        chk(d, 8'hF3);
        rd(RA, d);
        chk(d, 8'h6F);
    endtask
    // Flag write, result write and an unmapped read are all without effect
    task automatic t_misc();
        logic [7:0] d;
        wr(CA, 8'h30);
        rd(CA, d);
        chk(d, 8'hE0);
        wr(RA, 8'hAA);
        rd(RA, d);
        chk(d, 8'h00);
        rd(8'h90, d);
        chk(d, 8'h00);
    endtask
    // Codes above four pick no pin; dropping enable aborts a conversion
    task automatic t_sel_off();
        logic [7:0] d;
        wr(CA, 8'h26);
        @(posedge ref_clk);
        #1;
        chk({3'h0, analog_sel}, 8'h00);
        wr(CA, 8'h29);
        wr(CA, 8'h01);
        repeat (N) @(posedge ref_clk);
        rd(CA, d);
        chk(d, 8'hC1);
        rd(RA, d);
        chk(d, 8'h00);
    endtask
    task automatic t_pins();
        wr(CA, 8'h00);
        @(posedge ref_clk);
        port_latch <= 5'h16;
        ext_level  <= 5'h1F;
        repeat (5) @(posedge ref_clk);
        #1;
        chk({3'h0, pin_oe}, 8'h09);
        chk({3'h0, pin_out}, 8'h00);
        chk({3'h0, port_rd_data}, 8'h16);
    endtask

    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under 500 cycles
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset(1'b0);
        for (int c = 0; c < 5; c++) begin
            @(posedge ref_clk);
            irq_en <= c[0];
            t_convert(c);
        end
        t_busy();
        t_abort(1'b0);
        t_abort(1'b1);
        t_idle_keep();
        t_reset(1'b1);
        t_misc();
        t_sel_off();
        t_pins();
        close_out();
    end
endmodule
